// ---- stop_guard.sv ----
/*
 stop_guard.sv: stop-mode key guard and stop wake-up timer with an AHB-Lite
 register slave and one level interrupt.
 assumes: the core pulses i_stop_exec for one cycle when it executes STOP and
 obeys o_pc_to_reset and o_stop_mode; bus and core inputs are on i_mclk, while
 i_wake_event comes from a pin and is synchronised here.
 the bus master makes single word transfers; the slave never stalls and always
 answers OKAY; the two key registers sit at four times their index.
 reading the status register clears it; only the wake bit reaches o_wakeup_irq.
*/
// How it works
// - stop honoured only while key equals A5
// - wrong key: no stop, pc to reset
// - control bit 7 enables wake-up timer
// - timer tick is clock over two-power prescale
`timescale 1ns/10ps
`include "stop_guard_params.svh"
module stop_guard (
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic i_hsel,
	input wire logic [31:0] i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic [2:0] i_hsize,
	input wire logic [31:0] i_hwdata,
	input wire logic i_hready,
	output logic [31:0] o_hrdata,
	output logic o_hreadyout,
	output logic o_hresp,
	input wire logic i_stop_exec,
	input wire logic i_wake_event,
	output logic o_stop_mode,
	output logic o_pc_to_reset,
	output logic o_wakeup_irq,
	output logic o_irq
);
	stop_guard_pkg::stop_state_t state_reg;
	stop_guard_pkg::stop_state_t state_next;
	logic [7:0] key_reg;
	logic [7:0] wtc_reg;
	logic [15:0] count_reg;
	logic [15:0] count_next;
	logic [15:0] cmp_reg;
	logic [`IRQ_W-1:0] status_reg;
	logic [`IRQ_W-1:0] mask_reg;
	logic [`IRQ_W-1:0] status_next;
	logic [`IRQ_W-1:0] events;
	logic wr_pend_reg;
	logic [`ADDR_W-1:0] addr_reg;
	logic [31:0] rdata_reg;
	logic pc_reset_reg;
	logic wake_irq_reg;
	logic tick;

	// wake pin synchroniser and named fields
	logic wake_meta_reg;
	logic wake_sync_reg;
	logic [3:0] prescale_sel;
	logic [7:0] wdata_byte;
	logic [15:0] wdata_half;

	// ==========================================================
	// bus decode
	wire ap_valid = i_hsel && i_hready && i_htrans[1];
	wire [`ADDR_W-1:0] ap_addr = i_haddr[`ADDR_W-1:0];
	wire rd_go = ap_valid && !i_hwrite;
	wire wr_key = wr_pend_reg && (addr_reg == `OFS_STOP_ENABLE_KEY);
	wire wr_wtc = wr_pend_reg && (addr_reg == `OFS_WAKEUP_TIMER_CONTROL);
	wire wr_mask = wr_pend_reg && (addr_reg == `OFS_IRQ_MASK);
	wire wr_cmp = wr_pend_reg && (addr_reg == `OFS_COMPARE);
	wire rd_status = rd_go && (ap_addr == `OFS_IRQ_STATUS);

	// per-register hits; an unmapped address hits nothing and reads zero
	wire hit_wtc = (ap_addr == `OFS_WAKEUP_TIMER_CONTROL);
	wire hit_key = (ap_addr == `OFS_STOP_ENABLE_KEY);
	wire hit_status = (ap_addr == `OFS_IRQ_STATUS);
	wire hit_mask = (ap_addr == `OFS_IRQ_MASK);
	wire hit_count = (ap_addr == `OFS_WAKEUP_COUNT);
	wire hit_state = (ap_addr == `OFS_STOP_STATE);
	wire hit_cmp = (ap_addr == `OFS_COMPARE);

	// read words, unused upper bits zero
	wire [31:0] rd_wtc = {24'h000000, wtc_reg};
	wire [31:0] rd_key = {24'h000000, key_reg};
	wire [31:0] rd_stat = {29'h00000000, status_reg};
	wire [31:0] rd_mask = {29'h00000000, mask_reg};
	wire [31:0] rd_count = {16'h0000, count_reg};
	wire [31:0] rd_state = {30'h00000000, state_reg};
	wire [31:0] rd_cmp = {16'h0000, cmp_reg};
	wire [31:0] rd_mux =
		({32{hit_wtc}} & rd_wtc) |
		({32{hit_key}} & rd_key) |
		({32{hit_status}} & rd_stat) |
		({32{hit_mask}} & rd_mask) |
		({32{hit_count}} & rd_count) |
		({32{hit_state}} & rd_state) |
		({32{hit_cmp}} & rd_cmp);

	// ==========================================================
	// bus response and write data fields
	assign o_hreadyout = 1'b1;
	assign o_hresp = 1'b0;
	assign o_hrdata = rdata_reg;
	// writes take only the low bits that the target register holds
	assign wdata_byte = i_hwdata[7:0];
	assign wdata_half = i_hwdata[15:0];

	// ==========================================================
	// wake pin: two flops, only the second one feeds logic
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			wake_meta_reg <= 1'b0;
			wake_sync_reg <= 1'b0;
		end else begin
			wake_meta_reg <= i_wake_event;
			wake_sync_reg <= wake_meta_reg;
		end
	end

	// ==========================================================
	// stop guard
	wire in_run = (state_reg == stop_guard_pkg::ST_RUN);
	wire in_stop = (state_reg == stop_guard_pkg::ST_STOPPED);
	wire key_ok = (key_reg == `KEY_UNLOCK);
	// stop commands are judged only while running; a halted core sends none
	wire stop_ok = i_stop_exec && key_ok && in_run;
	wire stop_bad = i_stop_exec && !key_ok && in_run;
	wire timer_on = wtc_reg[`WTC_ENABLE_BIT];
	// count before the tick is compared, so wake comes on tick compare plus one
	wire wake_hit = timer_on && tick && (count_reg >= cmp_reg);
	wire wake = in_stop && (wake_sync_reg || wake_hit);

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			stop_guard_pkg::ST_RUN: begin
				if (stop_ok) begin
					state_next = stop_guard_pkg::ST_STOPPED;
				end
			end
			stop_guard_pkg::ST_STOPPED: begin
				if (wake) begin
					state_next = stop_guard_pkg::ST_RUN;
				end
			end
			default: begin
				state_next = stop_guard_pkg::ST_RUN;
			end
		endcase
	end

	assign o_stop_mode = (state_reg == stop_guard_pkg::ST_STOPPED);
	assign o_pc_to_reset = pc_reset_reg;
	assign o_wakeup_irq = wake_irq_reg;

	// ==========================================================
	// wake-up timer; counts only in stop so a stop starts from zero
	// a prescale above twelve is clamped inside the divider
	assign prescale_sel = wtc_reg[`WTC_PSEL_HI:`WTC_PSEL_LO];
	wakeup_prescaler u_prescaler (
		.i_mclk(i_mclk),
		.i_rst(i_rst),
		.i_enable(timer_on && o_stop_mode),
		.i_sel(prescale_sel),
		.o_tick(tick)
	);

	// the counter only moves in stop
	wire count_step = o_stop_mode && tick;
	assign count_next = !o_stop_mode ? 16'h0000 :
		(count_step ? count_reg + 16'h0001 : count_reg);

	// ==========================================================
	// interrupts: set wins over read clear
	assign events[`IRQ_BIT_WAKE] = wake_hit && o_stop_mode && wtc_reg[`WTC_IRQ_EN_BIT];
	assign events[`IRQ_BIT_REJECT] = stop_bad;
	assign events[`IRQ_BIT_STOP] = stop_ok;
	assign o_irq = |(status_reg & mask_reg);

	// one sticky flop per status bit; an event in the clearing read's cycle survives
	genvar gi;
	generate
		for (gi = 0; gi < `IRQ_W; gi++) begin : g_status
			assign status_next[gi] = (rd_status ? 1'b0 : status_reg[gi]) | events[gi];

			always_ff @(posedge i_mclk) begin
				if (i_rst) begin
					status_reg[gi] <= 1'b0;
				end else begin
					status_reg[gi] <= status_next[gi];
				end
			end
		end
	endgenerate

	// ==========================================================
	// guard state and wake-up counter
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			state_reg <= stop_guard_pkg::ST_RUN;
		end else begin
			state_reg <= state_next;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			count_reg <= 16'h0000;
		end else begin
			count_reg <= count_next;
		end
	end

	// ==========================================================
	// one-cycle answers; registered so the core sees a clean pulse
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			pc_reset_reg <= 1'b0;
		end else begin
			pc_reset_reg <= stop_bad;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			wake_irq_reg <= 1'b0;
		end else begin
			wake_irq_reg <= events[`IRQ_BIT_WAKE];
		end
	end

	// ==========================================================
	// register writes; control register bits 6 and 4 are held at zero whatever is written
	// a stop does not clear the key, software reloads it before each one
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			key_reg <= `KEY_RESET;
		end else if (wr_key) begin
			key_reg <= wdata_byte;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			wtc_reg <= `WTC_RESET;
		end else if (wr_wtc) begin
			wtc_reg <= wdata_byte & `WTC_WRITE_MASK;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			mask_reg <= {`IRQ_W{1'b0}};
		end else if (wr_mask) begin
			mask_reg <= i_hwdata[`IRQ_W-1:0];
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			cmp_reg <= `CMP_RESET;
		end else if (wr_cmp) begin
			cmp_reg <= wdata_half;
		end
	end

	// ==========================================================
	// bus data phase; a write lands one edge after its address phase
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			wr_pend_reg <= 1'b0;
		end else begin
			wr_pend_reg <= ap_valid && i_hwrite;
		end
	end

	// the address is kept for the data phase of a write
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			addr_reg <= {`ADDR_W{1'b0}};
		end else if (ap_valid) begin
			addr_reg <= ap_addr;
		end
	end

	// read data stands until the next read, not just one cycle
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			rdata_reg <= 32'h00000000;
		end else if (rd_go) begin
			rdata_reg <= rd_mux;
		end
	end
endmodule // stop_guard

// ---- stop_guard_params.svh ----
/*
 stop_guard_params.svh: offsets, field positions, reset values and codes of the
 stop-mode guard and wake-up timer.
 assumes: included by bare name by the design files; definitions only.
*/
`ifndef STOP_GUARD_PARAMS_SVH
`define STOP_GUARD_PARAMS_SVH

// ==========================================================
// register indices of the two key registers; each word sits at four times its index
`define IDX_WAKEUP_TIMER_CONTROL 12'h0FA
`define IDX_STOP_ENABLE_KEY 12'h0FD
`define OFS_WAKEUP_TIMER_CONTROL (`IDX_WAKEUP_TIMER_CONTROL << 2)
`define OFS_STOP_ENABLE_KEY (`IDX_STOP_ENABLE_KEY << 2)
// byte addresses of the block's own registers
`define OFS_IRQ_STATUS 12'h100
`define OFS_IRQ_MASK 12'h104
`define OFS_WAKEUP_COUNT 12'h108
`define OFS_STOP_STATE 12'h10C
`define OFS_COMPARE 12'h110
`define ADDR_W 12

// ==========================================================
// field positions and values
`define KEY_UNLOCK 8'hA5
`define KEY_RESET 8'h00
`define WTC_RESET 8'h00
`define WTC_ENABLE_BIT 7
`define WTC_IRQ_EN_BIT 5
`define WTC_PSEL_HI 3
`define WTC_PSEL_LO 0
`define WTC_WRITE_MASK 8'hAF
`define PRESCALE_MAX 4'hC
`define CMP_RESET 16'hFFFF
`define IRQ_BIT_WAKE 0
`define IRQ_BIT_REJECT 1
`define IRQ_BIT_STOP 2
`define IRQ_W 3

`endif

// ---- stop_guard_pkg.sv ----
/*
 stop_guard_pkg.sv: types shared by the stop-mode guard files.
 assumes: nothing beyond a SystemVerilog compiler.
*/
package stop_guard_pkg;
	// ==========================================================
	// guard state, one-hot
	typedef enum logic [1:0] {
		ST_RUN = 2'b01,
		ST_STOPPED = 2'b10
	} stop_state_t;
endpackage

// ---- wakeup_prescaler.sv ----
/*
 wakeup_prescaler.sv: power-of-two divider of the system clock, gives one
 tick pulse every 2**sel cycles while enabled.
 assumes: one clock, synchronous active-high reset, sel at most 12.
*/
`timescale 1ns/10ps
`include "stop_guard_params.svh"
module wakeup_prescaler (
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic i_enable,
	input wire logic [3:0] i_sel,
	output logic o_tick
);
	logic [11:0] div_reg;
	logic [11:0] div_next;
	logic [3:0] sel_clamp;
	wire [11:0] div_limit;

	// ==========================================================
	// clamp guards against illegal selections above twelve
	assign sel_clamp = (i_sel > `PRESCALE_MAX) ? `PRESCALE_MAX : i_sel;
	assign div_limit = 12'(({1'b0, 12'h000} | 13'h0001) << sel_clamp) - 12'h001;
	assign o_tick = i_enable && (div_reg >= div_limit);
	assign div_next = (!i_enable || o_tick) ? 12'h000 : div_reg + 12'h001;

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			div_reg <= 12'h000;
		end else begin
			div_reg <= div_next;
		end
	end
endmodule // wakeup_prescaler

// ---- stop_guard_assertions.sv ----
/*
 stop_guard_assertions.sv: port-level checker of the stop-mode guard.
 assumes: bound to stop_guard; one clock, synchronous active-high reset.
*/
`timescale 1ns/10ps
module stop_guard_assertions (
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic i_stop_exec,
	input wire logic o_stop_mode,
	input wire logic o_pc_to_reset,
	input wire logic o_wakeup_irq,
	input wire logic o_irq
);
	// ==========================================================
	// properties
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_rst);
	a_stop_needs_cmd: assert property ($rose(o_stop_mode) |-> $past(i_stop_exec))
		else $error("stop entered without a stop command");
	a_stop_one_answer: assert property (i_stop_exec && !o_stop_mode |=> o_stop_mode != o_pc_to_reset)
		else $error("stop command gave no single outcome");
	a_refuse_cause: assert property (o_pc_to_reset |-> $past(i_stop_exec) && !o_stop_mode)
		else $error("reset jump without refused stop");
	a_wake_from_stop: assert property (o_wakeup_irq |-> $past(o_stop_mode) || $past(o_stop_mode, 2))
		else $error("timer interrupt outside stop");
	a_wake_irq_pulse: assert property (o_wakeup_irq |=> !o_wakeup_irq)
		else $error("timer interrupt longer than one cycle");
	// ==========================================================
	// covers
	c_stop: cover property ($rose(o_stop_mode));
	c_refuse: cover property (o_pc_to_reset);
	c_wake_irq: cover property (o_wakeup_irq ##[1:4] o_irq);
endmodule // stop_guard_assertions

bind stop_guard stop_guard_assertions stop_guard_assertions_i (.i_mclk, .i_rst, .i_stop_exec,
	.o_stop_mode, .o_pc_to_reset, .o_wakeup_irq, .o_irq);

// ---- tb_stop_guard.sv ----
/*
 tb_stop_guard.sv: self-checking bench of the stop-mode guard.
 assumes: zero-wait slave; hready is the slave's own hreadyout.
*/
`timescale 1ns/10ps
`include "stop_guard_params.svh"
module tb_stop_guard;
	logic clk = 0, rst = 1, hsel = 0, hwrite = 0, se = 0, we = 0, seen = 0;
	logic [31:0] haddr = 0, hwdata = 0, q, hrdata;
	logic [1:0] htrans = 0;
	logic rdy, resp, smode, pcr, wirq, irq;
	int error_cnt = 0, n_tests = 0, n, ps, c;
	stop_guard stop_guard_i (.i_mclk(clk), .i_rst(rst), .i_hsel(hsel), .i_haddr(haddr),
		.i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
		.i_hready(rdy), .o_hrdata(hrdata), .o_hreadyout(rdy), .o_hresp(resp),
		.i_stop_exec(se), .i_wake_event(we), .o_stop_mode(smode), .o_pc_to_reset(pcr),
		.o_wakeup_irq(wirq), .o_irq(irq));
	// ==========================================================
	// clock, pulse catcher, watchdog
	initial forever #25 clk = ~clk;
	// the timer interrupt is a one-cycle pulse, so latch it
	always @(posedge clk) if (wirq === 1'b1) seen <= 1;
	initial begin
		repeat (30000) @(posedge clk);
		error_cnt++;
		give_verdict;
	end
	// ==========================================================
	// tasks
	task chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			error_cnt++;
			$display("unexpected at %0t: got %h want %h", $time, g, e);
		end
	endtask
	task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		hsel <= 1;
		htrans <= 2'h2;
		haddr <= {20'h0, a};
		hwrite <= w;
		do @(posedge clk); while (rdy !== 1'b1);
		hsel <= 0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (rdy !== 1'b1);
		q = hrdata;
		chk(resp, 0);
	endtask
	task stp(input logic ok);
		@(posedge clk);
		se <= 1;
		@(posedge clk);
		se <= 0;
		#1;
		chk(smode, ok);
		chk(pcr, !ok);
	endtask
	task give_verdict;
		if (error_cnt == 0 && n_tests > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	// ==========================================================
	// tests
	initial begin
		void'($urandom(13351));
		repeat (8) @(posedge clk);
		rst <= 0;
		bus(0, `OFS_STOP_ENABLE_KEY, 0);
		chk(q, `KEY_RESET);
		bus(0, 12'h1F0, 0);
		chk(q, 0);
		bus(1, `OFS_IRQ_MASK, 32'h1);
		// one-bit neighbours of the key first, then random wrong keys
		for (int i = 0; i < 6; i++) begin
			c = (i == 0) ? 8'hA4 : (i == 1) ? 8'h25 : $urandom % 256;
			if (c == 8'hA5) c = 0;
			bus(1, `OFS_STOP_ENABLE_KEY, c);
			stp(0);
		end
		// j 0: timer and interrupt on, j 1: interrupt off, j 2: timer off
		for (int j = 0; j < 3; j++) begin
			ps = $urandom % 4;
			c = 1 + $urandom % 3;
			bus(1, `OFS_COMPARE, c);
			bus(0, `OFS_COMPARE, 0);
			chk(q, c);
			bus(1, `OFS_WAKEUP_TIMER_CONTROL, {24'h0, j < 2, 2'h0 | (j == 0), 1'b0, 4'(ps)});
			bus(1, `OFS_STOP_ENABLE_KEY, `KEY_UNLOCK);
			bus(0, `OFS_IRQ_STATUS, 0);
			seen <= 0;
			stp(1);
			n = 0;
			while (smode === 1'b1 && n < 300) begin
				@(posedge clk);
				#1;
				n++;
			end
			if (j == 2) begin
				chk(n, 300);
				bus(0, `OFS_STOP_STATE, 0);
				chk(q, 32'h2);
				bus(0, `OFS_WAKEUP_COUNT, 0);
				chk(q, 0);
				@(posedge clk);
				we <= 1;
				@(posedge clk);
				we <= 0;
				repeat (2) @(posedge clk);
				#1;
				chk(smode, 0);
			end else chk(n >= (c << ps) && n <= ((c + 2) << ps) + 3, 1);
			repeat (3) @(posedge clk);
			#1;
			chk(seen, j == 0);
			chk(irq, j == 0);
			bus(0, `OFS_IRQ_STATUS, 0);
			chk(q[0], j == 0);
			chk(irq, 0);
		end
		// software keeps bits 6 and 4 at zero and a legal prescale
		c = $urandom % 256;
		c = c & 8'hA7;
		bus(1, `OFS_WAKEUP_TIMER_CONTROL, c);
		bus(0, `OFS_WAKEUP_TIMER_CONTROL, 0);
		chk(q, c);
		give_verdict;
	end
endmodule // tb_stop_guard
